// ==== wdt_defines.svh ====
// Register offsets, field positions, reset values and timing counts of the watchdog
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH
`define WDT_CTRL_ADDR 8'hc0
`define WDT_CTRL_RESET 8'h10
`define WDT_PRE_MSB 7
`define WDT_PRE_LSB 4
`define WDT_IIR_BIT 3
`define WDT_STS_BIT 2
`define WDT_EN_BIT 1
`define WDT_UNLOCK_BIT 0
`define WDT_PRE_MAX 4'h7
`define WDT_BASE_SHIFT 9
`define WDT_CLK_HZ 20000000
`define WDT_BASE_HZ 32768
`define WDT_BASE_DIV (`WDT_CLK_HZ / `WDT_BASE_HZ)
`define WDT_IMM_PRE 4'h8
`endif

// ==== wdt_pkg.sv ====
// Types shared by the watchdog design
package wdt_pkg;
	typedef enum logic [1:0] {
		WDT_LOCKED,
		WDT_OPEN
	} wdt_lock_t;
endpackage

// ==== wdt_tick.sv ====
// Time base tick generator deriving the 32.768 kHz rate from the core clock
`include "wdt_defines.svh"
module wdt_tick
	import wdt_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Tick pulse
	output logic tick
);
	localparam logic [31:0] DIV = 32'(`WDT_BASE_DIV);
	logic [31:0] cnt_reg;
	logic [31:0] cnt_next;
	logic tick_reg;
	logic tick_next;

	always_comb begin
		if (cnt_reg >= DIV - 32'h1) begin
			cnt_next = 32'h0;
			tick_next = 1'b1;
		end else begin
			cnt_next = cnt_reg + 32'h1;
			tick_next = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			cnt_reg <= 32'h0;
			tick_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign tick = tick_reg;
endmodule

// ==== wdt_top.sv ====
// Watchdog timer with its locked control register
`include "wdt_defines.svh"
module wdt_top
	import wdt_pkg::*;
(
	// Clock and hardware reset
	input wire logic clock,
	input wire logic resetn,
	// Special register access
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_bit_wr,
	input wire logic [2:0] sfr_bit_sel,
	input wire logic sfr_bit_val,
	output logic [7:0] sfr_rdata,
	// System events
	input wire logic supply_irq,
	output logic wdt_reset,
	output logic wdt_irq
);
	// ==========================================================
	// Time base
	logic tick;

	wdt_tick u_tick (
		.clock(clock),
		.resetn(resetn),
		.tick(tick)
	);

	// ==========================================================
	// Helper functions

	// Timeout limit of a prescale code, in base ticks
	function automatic logic [16:0] limit_of(input logic [3:0] code);
		limit_of = 17'(17'h1 << (`WDT_BASE_SHIFT + code));
	endfunction

	// Codes above the documented range time out at the next tick
	function automatic logic code_reserved(input logic [3:0] code);
		code_reserved = code > `WDT_PRE_MAX;
	endfunction

	// Byte or bit write aimed at the control register
	function automatic logic ctrl_hit(
		input logic [7:0] addr,
		input logic byte_wr,
		input logic bit_wr
	);
		ctrl_hit = (addr == `WDT_CTRL_ADDR) && (byte_wr || bit_wr);
	endfunction

	// Value that a byte or bit write would leave in the register
	function automatic logic [7:0] merge_write(
		input logic [7:0] cur,
		input logic bit_wr,
		input logic [2:0] sel,
		input logic bit_val,
		input logic [7:0] data
	);
		merge_write = data;
		if (bit_wr) begin
			merge_write = cur;
			merge_write[sel] = bit_val;
		end
	endfunction

	// ==========================================================
	// State and decode signals
	logic [7:0] ctrl_reg;
	logic [7:0] ctrl_next;
	logic [15:0] cnt_reg;
	logic [15:0] cnt_next;
	wdt_lock_t lock_reg;
	wdt_lock_t lock_next;
	logic rst_reg;
	logic rst_next;
	logic irq_reg;
	logic irq_next;
	logic [7:0] rd_reg;
	logic [7:0] rd_next;
	logic wr_hit;
	logic any_wr;
	logic [7:0] wval;
	logic timeout;
	logic [3:0] pre;

	// ==========================================================
	// Write decode
	always_comb begin
		wr_hit = ctrl_hit(sfr_addr, sfr_wr, sfr_bit_wr);
		wval = merge_write(ctrl_reg, sfr_bit_wr, sfr_bit_sel, sfr_bit_val, sfr_wdata);
		pre = ctrl_reg[`WDT_PRE_MSB:`WDT_PRE_LSB];
	end

	// ==========================================================
	// Write unlock
	always_comb begin
		lock_next = WDT_LOCKED;
		any_wr = 1'b0;
		if (wr_hit) begin
			if (lock_reg == WDT_OPEN) begin
				any_wr = 1'b1;
			end else if (wval[`WDT_UNLOCK_BIT]) begin
				lock_next = WDT_OPEN;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			lock_reg <= WDT_LOCKED;
		end else begin
			lock_reg <= lock_next;
		end
	end

	// ==========================================================
	// Timeout counter
	always_comb begin
		cnt_next = cnt_reg;
		timeout = 1'b0;
		if (ctrl_reg[`WDT_EN_BIT] && tick) begin
			cnt_next = cnt_reg + 16'h1;
			if (code_reserved(pre) || {1'b0, cnt_reg} + 17'h1 >= limit_of(pre)) begin
				timeout = 1'b1;
				cnt_next = 16'h0;
			end
		end
		if (!ctrl_reg[`WDT_EN_BIT]) begin
			cnt_next = 16'h0;
		end
		if (any_wr && wval[`WDT_EN_BIT]) begin
			cnt_next = 16'h0;
		end
		// reset action and supply monitor clear
		if ((timeout && !ctrl_reg[`WDT_IIR_BIT]) || supply_irq) begin
			cnt_next = 16'h0;
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			cnt_reg <= 16'h0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	// ==========================================================
	// Control register
	always_comb begin
		ctrl_next = ctrl_reg;
		if (any_wr) begin
			ctrl_next = wval;
		end
		// unlock bit shows the open window
		ctrl_next[`WDT_UNLOCK_BIT] = (lock_next == WDT_OPEN);
		if (timeout) begin
			ctrl_next[`WDT_STS_BIT] = 1'b1;
		end
		if (timeout && !ctrl_reg[`WDT_IIR_BIT]) begin
			ctrl_next[`WDT_EN_BIT] = 1'b0;
		end
		if (supply_irq) begin
			ctrl_next[`WDT_EN_BIT] = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			ctrl_reg <= `WDT_CTRL_RESET;
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	// ==========================================================
	// Event pulses and read back
	always_comb begin
		irq_next = timeout && ctrl_reg[`WDT_IIR_BIT];
		rst_next = timeout && !ctrl_reg[`WDT_IIR_BIT];
		rd_next = ctrl_next;
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			rst_reg <= 1'b0;
			irq_reg <= 1'b0;
			rd_reg <= `WDT_CTRL_RESET;
		end else begin
			rst_reg <= rst_next;
			irq_reg <= irq_next;
			rd_reg <= rd_next;
		end
	end

	assign sfr_rdata = rd_reg;
	assign wdt_reset = rst_reg;
	assign wdt_irq = irq_reg;
endmodule

// ==== wdt_top_properties.sv ====
// Checker of the watchdog register and timeout pulses
module wdt_chk(
	input wire logic clock,
	input wire logic resetn,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_bit_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	input wire logic supply_irq,
	input wire logic wdt_reset,
	input wire logic wdt_irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	wire hit = sfr_wr && sfr_addr == 8'hc0;
	wire ev = wdt_reset || wdt_irq;
	a_rst_val: assert property ($rose(resetn) |-> sfr_rdata == 8'h10) else $error("rst");
	a_lock_hold: assert property (hit && !sfr_rdata[0] && !sfr_wdata[0] |=>
		$stable(sfr_rdata[7:3])) else $error("lock");
	a_open_wr: assert property (hit && sfr_rdata[0] |=>
		sfr_rdata[7:3] == $past(sfr_wdata[7:3])) else $error("wr");
	a_one_pulse: assert property (ev |=> !ev) else $error("pulse");
	a_sts_set: assert property (ev |-> ##[0:1] sfr_rdata[2]) else $error("sts");
	a_off_quiet: assert property (!sfr_rdata[1] [*3] |-> !ev) else $error("off");
	a_sts_keep: assert property (sfr_rdata[2] && !sfr_wr && !sfr_bit_wr |=> sfr_rdata[2])
		else $error("keep");
	a_psm_off: assert property (supply_irq |=> !sfr_rdata[1]) else $error("psm");
	c_irq: cover property (wdt_irq);
	c_rst: cover property (wdt_reset);
	c_open: cover property (hit && sfr_rdata[0]);
endmodule
bind wdt_top wdt_chk u_chk (.*);

// ==== watchdog_timer_bench.sv ====
// Watchdog bench
module watchdog_timer_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 0, resetn = 0, sfr_wr = 0, sfr_bit_wr = 0, sfr_bit_val = 1, supply_irq = 0;
	logic [7:0] sfr_addr = 8'hc0, sfr_wdata = 8'h00, sfr_rdata, d;
	logic [2:0] sfr_bit_sel = 3'h1;
	logic wdt_reset, wdt_irq;
	logic [31:0] s = 32'hfa884ff6;
	int n_mismatch = 0, n_tests = 0;
	wdt_top DUT (.*);
	initial forever #25 clock = ~clock;
	initial begin
		#1000000;
		n_mismatch++;
		stop_test();
	end
	function logic [31:0] xs(logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction
	task cyc;
		@(posedge clock);
		#5;
	endtask
	task chk(logic [7:0] a, e);
		n_tests++;
		if (a !== e) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h want %h", $time, a, e);
		end
	endtask
	task wr(logic [7:0] v, logic u = 1);
		sfr_wr = 1;
		if (u) begin
			sfr_wdata = 8'h01;
			cyc();
		end
		sfr_wdata = v;
		cyc();
		sfr_wr = 0;
		cyc();
	endtask
	task ev(logic [1:0] e);
		repeat (1300) if (!(wdt_irq | wdt_reset)) cyc();
		chk({6'h0, wdt_irq, wdt_reset}, {6'h0, e});
	endtask
	task stop_test;
		if (n_mismatch == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (12) cyc();
		resetn = 1;
		cyc();
		chk(sfr_rdata, 8'h10);
		wr(8'hf6, 0);
		sfr_addr = 8'hc1;
		wr(8'h7a);
		sfr_addr = 8'hc0;
		chk(sfr_rdata, 8'h10);
		repeat (20) begin
			s = xs(s);
			d = s[7:0] & 8'h7a;
			wr(d);
			chk(sfr_rdata, d);
		end
		wr(8'h88);
		ev(2'b00);
		wr(8'h8a);
		ev(2'b10);
		wr(8'h82);
		ev(2'b01);
		cyc();
		chk(sfr_rdata, 8'h84);
		wr(8'h00);
		chk(sfr_rdata, 8'h00);
		sfr_wr = 1;
		sfr_wdata = 8'h01;
		cyc();
		sfr_wr = 0;
		sfr_bit_wr = 1;
		cyc();
		sfr_bit_wr = 0;
		chk(sfr_rdata, 8'h02);
		ev(2'b00);
		supply_irq = 1;
		cyc();
		supply_irq = 0;
		chk(sfr_rdata, 8'h00);
		stop_test();
	end
endmodule
